// *** dasb_bank.sv ***
/*
 * Attribute bank 19h..47h plus general status and fault sense bytes of a disk drive.
 * Assumes command decoding outside: one-cycle strobes with a parameter byte, synchronous to ref_clk_i.
 */
`timescale 1ns/10ps
`include "dasb_regs.svh"

module dasb_bank (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire dasb_pkg::dasb_cmd_t cmd_i,
	input wire logic [7:0] parm_i,
	input wire dasb_pkg::dasb_event_t event_i,
	input wire logic [7:0] sense2_i,
	input wire logic rezero_ok_i,
	input wire logic power_ok_i,
	input wire logic speed_ok_i,
	output logic [7:0] report_data_o,
	output logic report_valid_o,
	output logic [7:0] general_status_o,
	output logic [7:0] fault_sense_o,
	output logic [7:0] attr_number_o,
	output logic attention_o
);
	import dasb_pkg::*;

	function automatic logic known_attr(input logic [7:0] n);
		known_attr = (n == `DASB_NUM_SECTORING) || (n >= `DASB_NUM_CYL_HIGH && n <= `DASB_NUM_HEADS)
			|| (n >= `DASB_NUM_HDR_ENC && n <= `DASB_NUM_HDR_GAP_PAT)
			|| (n >= `DASB_NUM_DAT_ENC && n <= `DASB_NUM_DAT_GAP_PAT);
	endfunction : known_attr

	function automatic logic code_ok(input logic [7:0] v);
		code_ok = (v == `DASB_ENC_MFM) || (v == `DASB_ENC_GCR);
	endfunction : code_ok

	// Attribute storage
	logic [7:0] attr_number;
	logic [7:0] sectoring_method;
	logic [15:0] cylinder_count;
	logic [7:0] moving_head_count;
	logic [7:0] hdr [0:7];
	logic [7:0] dat [0:7];

	// Status storage
	logic bus_error;
	logic illegal_cmd;
	logic illegal_parm;
	logic not_ready;
	logic busy;
	logic complete;
	logic [7:0] fault_sense;
	logic attention;
	logic [7:0] sense2_q;
	logic [7:0] sense1_q;
	logic nr_q;
	logic [2:0] gs_q;
	dasb_state_t state;

	// Decode of the selected attribute
	wire logic sel_known = known_attr(attr_number);
	wire logic sel_hdr = attr_number[7:4] == 4'h3 && !attr_number[3];
	wire logic sel_dat = attr_number[7:4] == 4'h4 && !attr_number[3];
	wire logic [2:0] sel_idx = attr_number[2:0];
	wire logic is_load = cmd_i.load;
	wire logic load_unknown = is_load && !sel_known;
	wire logic sect_bad = parm_i != `DASB_SECT_INVALID && parm_i != `DASB_SECT_HARD;
	wire logic load_bad = is_load && sel_known && (
		(attr_number == `DASB_NUM_SECTORING && sect_bad)
		|| (attr_number == `DASB_NUM_CYL_LOW && cylinder_count[15:8] == 8'h00 && parm_i == 8'h00)
		|| (attr_number == `DASB_NUM_CYL_HIGH && cylinder_count[7:0] == 8'h00 && parm_i == 8'h00)
		|| (attr_number == `DASB_NUM_HEADS && parm_i == 8'h00)
		|| ((attr_number == `DASB_NUM_HDR_ENC || attr_number == `DASB_NUM_DAT_ENC) && !code_ok(parm_i)));
	wire logic load_ok = is_load && sel_known && !load_bad;
	wire logic sel_bad_num = cmd_i.sel_num && !known_attr(parm_i);

	// Fault sense next value: set wins over clear
	logic [7:0] sense_set;
	logic [7:0] sense_keep;
	assign sense_set = {2'b00, event_i.cmd_reject, event_i.speed_error, 1'b0,
		event_i.power_fault, event_i.rw_fault, event_i.seek_error};
	assign sense_keep[`DASB_S1_SEEK] = !rezero_ok_i && !cmd_i.clear_fault;
	assign sense_keep[`DASB_S1_RW] = !cmd_i.clear_fault;
	assign sense_keep[`DASB_S1_POWER] = !(cmd_i.clear_fault && power_ok_i);
	assign sense_keep[3] = 1'b0;
	assign sense_keep[`DASB_S1_SPEED] = !(cmd_i.clear_fault && speed_ok_i);
	assign sense_keep[`DASB_S1_REJECT] = !cmd_i.clear_fault;
	assign sense_keep[7:6] = 2'b00;
	wire logic [7:0] next_fault_sense = ((fault_sense & sense_keep) | sense_set) & `DASB_S1_MASK;

	wire logic next_bus_error = event_i.bus_error || (bus_error && !cmd_i.clear_fault);
	wire logic next_illegal_cmd = event_i.illegal_cmd || load_unknown || sel_bad_num
		|| (illegal_cmd && !cmd_i.clear_fault);
	wire logic next_illegal_parm = event_i.illegal_parm || load_bad
		|| (illegal_parm && !cmd_i.clear_fault);
	wire logic next_complete = event_i.complete || (complete && !cmd_i.clear_attn);

	// General status assembly
	wire logic [7:0] status_byte = {complete, busy, |sense2_i, |fault_sense,
		illegal_parm, illegal_cmd, bus_error, not_ready};

	// Attention on rising edges of flagged bits and any ready change
	wire logic [2:0] gs_att = {illegal_parm, illegal_cmd, bus_error};
	wire logic rise = (|(gs_att & ~gs_q)) || (|(fault_sense & ~sense1_q))
		|| (|(sense2_i & ~sense2_q & 8'h23));
	wire logic ready_change = not_ready != nr_q;
	wire logic next_attention = rise || ready_change || (attention && !cmd_i.clear_attn);

	// Report multiplexer
	logic [7:0] attr_value;
	always_comb begin
		attr_value = 8'h00;
		if (attr_number == `DASB_NUM_SECTORING)
			attr_value = sectoring_method;
		else if (attr_number == `DASB_NUM_CYL_HIGH)
			attr_value = cylinder_count[15:8];
		else if (attr_number == `DASB_NUM_CYL_LOW)
			attr_value = cylinder_count[7:0];
		else if (attr_number == `DASB_NUM_HEADS)
			attr_value = moving_head_count;
		else if (sel_hdr)
			attr_value = hdr[sel_idx];
		else if (sel_dat)
			attr_value = dat[sel_idx];
	end

	// Scalar attribute write enables and next values
	wire logic we_sectoring = load_ok && attr_number == `DASB_NUM_SECTORING;
	wire logic we_cyl_high = load_ok && attr_number == `DASB_NUM_CYL_HIGH;
	wire logic we_cyl_low = load_ok && attr_number == `DASB_NUM_CYL_LOW;
	wire logic we_heads = load_ok && attr_number == `DASB_NUM_HEADS;
	wire logic [7:0] next_attr_number = (cmd_i.sel_num && !sel_bad_num) ? parm_i : attr_number;
	wire logic [7:0] next_sectoring_method = we_sectoring ? parm_i : sectoring_method;
	wire logic [7:0] next_cyl_high = we_cyl_high ? parm_i : cylinder_count[15:8];
	wire logic [7:0] next_cyl_low = we_cyl_low ? parm_i : cylinder_count[7:0];
	wire logic [7:0] next_moving_head_count = we_heads ? parm_i : moving_head_count;

	// Selected attribute number
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			attr_number <= `DASB_NUM_SECTORING;
		end else begin
			attr_number <= next_attr_number;
		end
	end

	// Sectoring method
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sectoring_method <= `DASB_RST_SECTORING;
		end else begin
			sectoring_method <= next_sectoring_method;
		end
	end

	// Cylinder count, both bytes
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cylinder_count <= `DASB_RST_CYL;
		end else begin
			cylinder_count <= {next_cyl_high, next_cyl_low};
		end
	end

	// Moving head count
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			moving_head_count <= `DASB_RST_HEADS;
		end else begin
			moving_head_count <= next_moving_head_count;
		end
	end

	// Reset value of one field format slot
	function automatic logic [7:0] fmt_reset(input int idx);
		case (idx)
			0: fmt_reset = `DASB_RST_ENC;
			3: fmt_reset = `DASB_RST_SYNC;
			1, 4, 6: fmt_reset = `DASB_RST_LEN;
			default: fmt_reset = `DASB_RST_PAT;
		endcase
	endfunction : fmt_reset

	// Field format attributes, header then data group
	wire logic [7:0] hdr_we;
	wire logic [7:0] dat_we;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_hdr
			localparam logic [7:0] RST = fmt_reset(gi);
			assign hdr_we[gi] = load_ok && sel_hdr && sel_idx == 3'(gi);
			always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					hdr[gi] <= RST;
				end else if (hdr_we[gi]) begin
					hdr[gi] <= parm_i;
				end
			end
		end
		for (gi = 0; gi < 8; gi++) begin : g_dat
			localparam logic [7:0] RST = fmt_reset(gi);
			assign dat_we[gi] = load_ok && sel_dat && sel_idx == 3'(gi);
			always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					dat[gi] <= RST;
				end else if (dat_we[gi]) begin
					dat[gi] <= parm_i;
				end
			end
		end
	endgenerate

	// Control bus error, sticky until clear fault
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bus_error <= 1'b0;
		end else begin
			bus_error <= next_bus_error;
		end
	end

	// Illegal command, sticky until clear fault
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			illegal_cmd <= 1'b0;
		end else begin
			illegal_cmd <= next_illegal_cmd;
		end
	end

	// Illegal parameter, sticky until clear fault
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			illegal_parm <= 1'b0;
		end else begin
			illegal_parm <= next_illegal_parm;
		end
	end

	// Not ready follows the drive
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			not_ready <= 1'b1;
		end else begin
			not_ready <= event_i.not_ready;
		end
	end

	// Busy follows execution
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			busy <= 1'b0;
		end else begin
			busy <= event_i.busy;
		end
	end

	// Normal complete, sticky until clear attention
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			complete <= 1'b0;
		end else begin
			complete <= next_complete;
		end
	end

	// Fault sense byte
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fault_sense <= 8'h00;
		end else begin
			fault_sense <= next_fault_sense;
		end
	end

	// Previous status flags for edge detection
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			gs_q <= 3'h0;
		end else begin
			gs_q <= gs_att;
		end
	end

	// Previous fault sense byte
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sense1_q <= 8'h00;
		end else begin
			sense1_q <= fault_sense;
		end
	end

	// Previous sense byte 2
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sense2_q <= 8'h00;
		end else begin
			sense2_q <= sense2_i;
		end
	end

	// Previous not ready, idle level matches its reset
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			nr_q <= 1'b1;
		end else begin
			nr_q <= not_ready;
		end
	end

	// Attention condition
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			attention <= 1'b0;
		end else begin
			attention <= next_attention;
		end
	end

	// Report answer one cycle after the request; a report during the reply is ignored
	wire logic take_report = state == DASB_IDLE && cmd_i.report;
	wire logic [7:0] next_report_data = take_report ? (sel_known ? attr_value : status_byte) : report_data_o;

	// Reply byte
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			report_data_o <= 8'h00;
		end else begin
			report_data_o <= next_report_data;
		end
	end

	// Reply state
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= DASB_IDLE;
		end else begin
			case (state)
				DASB_IDLE: begin
					if (cmd_i.report) begin
						state <= DASB_REPLY;
					end
				end
				DASB_REPLY: begin
					state <= DASB_IDLE;
				end
				default: begin
					state <= DASB_IDLE;
				end
			endcase
		end
	end

	assign report_valid_o = state == DASB_REPLY;
	assign general_status_o = status_byte;
	assign fault_sense_o = fault_sense;
	assign attr_number_o = attr_number;
	assign attention_o = attention;

endmodule : dasb_bank

// *** dasb_regs.svh ***
/*
 * Attribute numbers, status bit positions and attribute codes for the disk attribute and status bank.
 * Assumes the including file uses these as plain constants.
 */
`ifndef DASB_REGS_SVH
`define DASB_REGS_SVH

`define DASB_NUM_SECTORING 8'h19
`define DASB_NUM_CYL_HIGH 8'h20
`define DASB_NUM_CYL_LOW 8'h21
`define DASB_NUM_HEADS 8'h22
`define DASB_NUM_HDR_ENC 8'h30
`define DASB_NUM_HDR_PRE_LEN 8'h31
`define DASB_NUM_HDR_PRE_PAT 8'h32
`define DASB_NUM_HDR_SYNC 8'h33
`define DASB_NUM_HDR_POST_LEN 8'h34
`define DASB_NUM_HDR_POST_PAT 8'h35
`define DASB_NUM_HDR_GAP_LEN 8'h36
`define DASB_NUM_HDR_GAP_PAT 8'h37
`define DASB_NUM_DAT_ENC 8'h40
`define DASB_NUM_DAT_PRE_LEN 8'h41
`define DASB_NUM_DAT_PRE_PAT 8'h42
`define DASB_NUM_DAT_SYNC 8'h43
`define DASB_NUM_DAT_POST_LEN 8'h44
`define DASB_NUM_DAT_POST_PAT 8'h45
`define DASB_NUM_DAT_GAP_LEN 8'h46
`define DASB_NUM_DAT_GAP_PAT 8'h47

`define DASB_SECT_INVALID 8'h00
`define DASB_SECT_HARD 8'h01
`define DASB_ENC_MFM 8'h00
`define DASB_ENC_GCR 8'h01

`define DASB_GS_NOT_READY 0
`define DASB_GS_BUS_ERR 1
`define DASB_GS_ILL_CMD 2
`define DASB_GS_ILL_PARM 3
`define DASB_GS_SENSE1 4
`define DASB_GS_SENSE2 5
`define DASB_GS_BUSY 6
`define DASB_GS_COMPLETE 7

`define DASB_S1_SEEK 0
`define DASB_S1_RW 1
`define DASB_S1_POWER 2
`define DASB_S1_SPEED 4
`define DASB_S1_REJECT 5
`define DASB_S1_MASK 8'h37

`define DASB_RST_SECTORING 8'h01
`define DASB_RST_CYL 16'h0400
`define DASB_RST_HEADS 8'h04
`define DASB_RST_ENC 8'h00
`define DASB_RST_LEN 8'h0a
`define DASB_RST_PAT 8'h00
`define DASB_RST_SYNC 8'ha1

`endif

// *** dasb_pkg.sv ***
/*
 * Types shared by the disk attribute and status bank.
 * Assumes dasb_regs.svh supplies the numeric constants.
 */
package dasb_pkg;

	typedef struct packed {
		logic sel_num;
		logic load;
		logic report;
		logic clear_fault;
		logic clear_attn;
	} dasb_cmd_t;

	typedef struct packed {
		logic bus_error;
		logic illegal_cmd;
		logic illegal_parm;
		logic not_ready;
		logic busy;
		logic complete;
		logic seek_error;
		logic rw_fault;
		logic power_fault;
		logic speed_error;
		logic cmd_reject;
	} dasb_event_t;

	typedef enum logic [1:0] {
		DASB_IDLE,
		DASB_REPLY
	} dasb_state_t;

endpackage : dasb_pkg

// *** dasb_host.sv ***
/* Host controller model: turns an opcode into one command strobe.
   Assumes the bench changes op_i and byte_i at rising edges. */
`timescale 1ns/10ps
module dasb_host (
	input wire logic [2:0] op_i,
	input wire logic [7:0] byte_i,
	output dasb_pkg::dasb_cmd_t cmd_o,
	output logic [7:0] parm_o
);
	import dasb_pkg::*;
	// Op 1 select, 2 load, 3 report, 4 clear fault, 5 clear attention
	assign cmd_o = (op_i == 3'h0) ? '0 : dasb_cmd_t'(5'h10 >> (op_i - 3'h1));
	// Parameter byte passes through unchanged, all eight bits in parallel
	assign parm_o = byte_i;
endmodule : dasb_host

// *** dasb_bank_props.sv ***
/* Checker for status, attention and select timing of dasb_bank.
   Assumes it is bound to dasb_bank. */
`timescale 1ns/10ps
module dasb_bank_props (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire dasb_pkg::dasb_cmd_t cmd_i,
	input wire logic [7:0] parm_i,
	input wire dasb_pkg::dasb_event_t event_i,
	input wire logic [7:0] sense2_i,
	input wire logic power_ok_i,
	input wire logic speed_ok_i,
	input wire logic [7:0] general_status_o,
	input wire logic [7:0] fault_sense_o,
	input wire logic [7:0] attr_number_o,
	input wire logic attention_o
);
	import dasb_pkg::*;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	logic [7:0] flags;
	assign flags = {fault_sense_o[5:1], general_status_o[3:1]};
	sequence s_parm_flag;
		general_status_o[3] ##1 attention_o;
	endsequence
	chk_fault_sticky: assert property (!cmd_i.clear_fault |=> (flags & $past(flags)) == $past(flags))
		else $error("fault bit lost");
	chk_fault_clear: assert property (cmd_i.clear_fault && power_ok_i && speed_ok_i && !cmd_i.load
		&& !cmd_i.sel_num && event_i[10:8] == 3'h0 && event_i[4:0] == 5'h00 |=> flags == 8'h00)
		else $error("fault bit kept");
	chk_attn_rise: assert property (!cmd_i.clear_attn && (flags & ~$past(flags)) != 0 |=> attention_o)
		else $error("no attention on fault");
	chk_ready_attn: assert property ($changed(general_status_o[0]) |=> attention_o)
		else $error("no attention on ready change");
	chk_sense_or: assert property (general_status_o[5:4] == {|sense2_i, |fault_sense_o})
		else $error("sense summary wrong");
	chk_spare_zero: assert property ((fault_sense_o & 8'hc8) == 0)
		else $error("spare sense bit set");
	chk_bad_select: assert property (cmd_i.sel_num && parm_i == 8'h00 |=> general_status_o[2] && $stable(attr_number_o))
		else $error("bad select missed");
	chk_bad_encoding: assert property (cmd_i.load && attr_number_o == 8'h30 && parm_i > 8'h01 |=> s_parm_flag)
		else $error("bad encoding missed");
endmodule : dasb_bank_props

// *** tb_dasb_bank.sv ***
/* Top testbench of dasb_bank: host model, loads, reports and events.
   Assumes dasb_host and dasb_bank_props compiled before it. */
`timescale 1ns/10ps
`include "dasb_regs.svh"
module tb_dasb_bank;
	import dasb_pkg::*;
	logic ref_clk_i = 0;
	logic arst_n_i = 0;
	logic [2:0] op = 0;
	logic [7:0] byt = 0, s2 = 0, pm, rd, gs, fs, an;
	logic pok = 1, sok = 1, rz = 0, av, att;
	dasb_event_t ev = 11'h080;
	dasb_cmd_t cmd;
	int fail_count = 0, n_tests = 0;
	logic [31:0] seed = 32'h4dd5;
	logic [7:0] m [256];
	logic [7:0] nums [20] = '{8'h19, 8'h20, 8'h21, 8'h22, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36,
		8'h37, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47};
	always #5 ref_clk_i = ~ref_clk_i;
	dasb_host i_dasb_host (.op_i(op), .byte_i(byt), .cmd_o(cmd), .parm_o(pm));
	dasb_bank i_dasb_bank (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .cmd_i(cmd), .parm_i(pm), .event_i(ev),
		.sense2_i(s2), .rezero_ok_i(rz), .power_ok_i(pok), .speed_ok_i(sok), .report_data_o(rd),
		.report_valid_o(av), .general_status_o(gs), .fault_sense_o(fs), .attr_number_o(an), .attention_o(att));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [7:0] rv(input logic [7:0] n);
		case (n)
			8'h19: return `DASB_RST_SECTORING;
			8'h20: return 8'(`DASB_RST_CYL >> 8);
			8'h21: return 8'(`DASB_RST_CYL);
			8'h22: return `DASB_RST_HEADS;
			8'h30, 8'h40: return `DASB_RST_ENC;
			8'h31, 8'h34, 8'h36, 8'h41, 8'h44, 8'h46: return `DASB_RST_LEN;
			8'h33, 8'h43: return `DASB_RST_SYNC;
			default: return `DASB_RST_PAT;
		endcase
	endfunction : rv
	function automatic logic ok(input logic [7:0] n, v);
		case (n)
			8'h19, 8'h30, 8'h40: return v < 8'h02;
			8'h22: return v != 8'h00;
			8'h20: return (v | m[8'h21]) != 8'h00;
			8'h21: return (v | m[8'h20]) != 8'h00;
			default: return 1'b1;
		endcase
	endfunction : ok
	task automatic chk(input string nm, input logic [7:0] e, g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic do_cmd(input logic [2:0] o, input logic [7:0] b);
		@(posedge ref_clk_i);
		op <= o;
		byt <= b;
		@(posedge ref_clk_i);
		op <= 3'h0;
		#1;
	endtask : do_cmd
	task automatic rd_attr(input logic [7:0] n);
		do_cmd(3'h1, n);
		do_cmd(3'h3, 8'h00);
		chk("reply valid", 8'h01, 8'(av));
		chk("attribute", m[n], rd);
		@(posedge ref_clk_i);
		#1;
		chk("reply ended", 8'h00, 8'(av));
	endtask : rd_attr
	task automatic ld(input logic [7:0] n, v);
		logic g;
		g = ok(n, v);
		do_cmd(3'h1, n);
		do_cmd(3'h2, v);
		chk("bad value flag", 8'(!g), 8'(gs[3]));
		if (g) begin
			m[n] = v;
		end
		@(posedge ref_clk_i);
		#1;
		chk("attention", 8'(!g), 8'(att));
		do_cmd(3'h4, 8'h00);
		do_cmd(3'h5, 8'h00);
		rd_attr(n);
	endtask : ld
	task automatic pulse(input logic [10:0] p);
		@(posedge ref_clk_i);
		ev <= ev | p;
		@(posedge ref_clk_i);
		ev <= ev & ~p;
		repeat (2) @(posedge ref_clk_i);
		#1;
	endtask : pulse
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test
	initial begin
		#200000;
		fail_count++;
		stop_test();
	end
	initial begin
		logic [7:0] v;
		logic ae;
		for (int i = 0; i < 256; i++) begin
			m[i] = rv(8'(i));
		end
		repeat (8) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
		@(posedge ref_clk_i);
		#1;
		chk("reset status", 8'h01, gs);
		foreach (nums[i]) rd_attr(nums[i]);
		for (int k = 0; k < 60; k++) begin
			v = 8'(rnd());
			if (v[7]) begin
				v = 8'(v % 3);
			end
			ld(nums[rnd() % 20], v);
		end
		ld(8'h20, 8'h00);
		ld(8'h21, 8'h00);
		ld(8'h20, 8'h00);
		do_cmd(3'h1, 8'h00);
		chk("bad select", 8'h04, gs & 8'h0e);
		chk("number kept", 8'h20, an);
		pulse(11'h700);
		chk("fault sticky", 8'h0e, gs & 8'h0e);
		chk("attention", 8'h01, 8'(att));
		do_cmd(3'h4, 8'h00);
		do_cmd(3'h5, 8'h00);
		chk("fault cleared", 8'h00, gs & 8'h0e);
		chk("attention off", 8'h00, 8'(att));
		for (int i = 0; i < 5; i++) begin
			v = 8'(8'h01 << (i + int'(i > 2)));
			pulse(11'(11'h010 >> i));
			chk("fault sense", v, fs);
			chk("sense1 summary", 8'h10, gs & 8'h10);
			chk("attention", 8'h01, 8'(att));
			@(posedge ref_clk_i);
			pok <= (i != 2);
			sok <= (i != 3);
			do_cmd(3'h4, 8'h00);
			chk("fault gated", (i == 2 || i == 3) ? v : 8'h00, fs);
			@(posedge ref_clk_i);
			pok <= 1'b1;
			sok <= 1'b1;
			do_cmd(3'h4, 8'h00);
			do_cmd(3'h5, 8'h00);
			chk("fault cleared", 8'h00, fs);
		end
		pulse(11'h010);
		@(posedge ref_clk_i);
		rz <= 1'b1;
		@(posedge ref_clk_i);
		rz <= 1'b0;
		@(posedge ref_clk_i);
		#1;
		chk("rezero clear", 8'h00, fs);
		@(posedge ref_clk_i);
		ev.not_ready <= 1'b0;
		ev.busy <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		#1;
		chk("ready busy", 8'h40, gs & 8'h41);
		chk("attention", 8'h01, 8'(att));
		do_cmd(3'h5, 8'h00);
		@(posedge ref_clk_i);
		ev.busy <= 1'b0;
		pulse(11'h020);
		chk("complete", 8'h80, gs & 8'hc0);
		do_cmd(3'h4, 8'h00);
		chk("complete held", 8'h80, gs & 8'h80);
		do_cmd(3'h5, 8'h00);
		chk("complete cleared", 8'h00, gs & 8'h80);
		ae = 1'b0;
		for (int k = 0; k < 4; k++) begin
			@(posedge ref_clk_i);
			v = (k == 0) ? 8'h00 : 8'(rnd());
			ae = ae | ((v & ~s2 & 8'h23) != 8'h00);
			s2 <= v;
			@(posedge ref_clk_i);
			#1;
			chk("sense2 summary", {2'b00, |s2, 5'h00}, gs & 8'h20);
			chk("sense2 attention", 8'(ae), 8'(att));
		end
		stop_test();
	end
endmodule : tb_dasb_bank
bind dasb_bank dasb_bank_props i_dasb_bank_props (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .cmd_i(cmd_i),
	.parm_i(parm_i), .event_i(event_i), .sense2_i(sense2_i), .power_ok_i(power_ok_i), .speed_ok_i(speed_ok_i),
	.general_status_o(general_status_o), .fault_sense_o(fault_sense_o), .attr_number_o(attr_number_o),
	.attention_o(attention_o));
